// ### common/sysopt_pkg.sv
// Purpose: shared constants and carriers for the system option block
// Assumes: 8-bit registers, one per 32-bit wishbone word
// Notes:   period table holds terminal counts, one less than the period
package sysopt_pkg;

  localparam int ADR_W = 8;
  localparam int CNT_W = 16;

  // register byte addresses
  localparam logic [ADR_W-1:0] OFF_OPT_ONE   = 8'h00;
  localparam logic [ADR_W-1:0] OFF_OPT_TWO   = 8'h04;
  localparam logic [ADR_W-1:0] OFF_ID_HIGH   = 8'h08;
  localparam logic [ADR_W-1:0] OFF_ID_LOW    = 8'h0C;
  localparam logic [ADR_W-1:0] OFF_WAKE_CTRL = 8'h10;

  // system_options_one layout and reset
  localparam int OPT1_WDOG_EN    = 7;
  localparam int OPT1_WDOG_LONG  = 6;
  localparam int OPT1_STOP_OK    = 5;
  localparam int OPT1_SPARE      = 4;
  localparam int OPT1_DBG_PIN    = 1;
  localparam int OPT1_RST_PIN    = 0;
  localparam logic [7:0] OPT1_RESET = 8'hD2;
  localparam logic [7:0] OPT1_MASK  = 8'hF3;

  // system_options_two layout and reset
  localparam int OPT2_WDOG_CLK = 7;
  localparam logic [7:0] OPT2_RESET = 8'h00;
  localparam logic [7:0] OPT2_MASK  = 8'h80;

  // wakeup_timer_ctrl_status layout and reset
  localparam int WAKE_FLAG   = 7;
  localparam int WAKE_ACK    = 6;
  localparam int WAKE_CLKSEL = 5;
  localparam int WAKE_IRQEN  = 4;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [7:0] WAKE_MASK  = 8'h37;

  // terminal counts per period code, slow 1 kHz base and 32 kHz base
  localparam logic [CNT_W-1:0] TERM_SLOW [8] = '{16'h0000, 16'h0007,
    16'h001F, 16'h003F, 16'h007F, 16'h00FF, 16'h01FF, 16'h03FF};
  localparam logic [CNT_W-1:0] TERM_FAST [8] = '{16'h0000, 16'h00FF,
    16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h3FFF, 16'h7FFF};

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic watchdogEnable;
    logic watchdogLongTimeout;
    logic watchdogClockSelect;
    logic stopPermit;
    logic debugPinEnable;
    logic resetPinEnable;
  } sysopt_t;

endpackage

// ### logic/wakeup_counter.sv
// Purpose: periodic wakeup period counter driven by a tick enable
// Assumes: tick is a one-cycle enable from the chosen time base
// Notes:   any change of period or base restarts the count
`timescale 1ns/10ps
`default_nettype none
module wakeup_counter
  import sysopt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       fastBase,
  input  wire logic [2:0] periodSel,
  output logic            timeout
);

  logic [CNT_W-1:0] count_r, count_nxt;
  logic [CNT_W-1:0] term;
  logic [3:0]       cfg_r, cfg_nxt;
  logic             timeout_r, timeout_nxt;

  // restart on config change so a new period starts cleanly
  always_comb begin
    term        = fastBase ? TERM_FAST[periodSel] : TERM_SLOW[periodSel];
    cfg_nxt     = {fastBase, periodSel};
    count_nxt   = count_r;
    timeout_nxt = 1'b0;
    if (periodSel == 3'h0 || cfg_r != cfg_nxt) begin
      count_nxt = '0; // R20
    end else if (tick) begin
      if (count_r >= term) begin
        count_nxt   = '0;
        timeout_nxt = 1'b1; // R20
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r   <= '0;
      cfg_r     <= 4'h0;
      timeout_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      cfg_r     <= cfg_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign timeout = timeout_r;

endmodule
`default_nettype wire

// ### logic/system_option_id_regs.sv
// Purpose: write-once system options, part identity, wakeup control
// Assumes: classic wishbone slave, 32-bit data, byte lane 0 used
// Notes:   powerOnReset qualifies rst; pads are synchronised here
//
// Contract
// R1 - first system options register takes only first write per reset
// R2 - init software writes first options register once after reset
// R3 - reserved bit 4 stores written value yet steers nothing
// R4 - bit 7 zero disables watchdog, one enables timeout reset
// R5 - bit 6 picks short or long watchdog timeout
// R6 - bit 5 permits stop; else stop forces illegal-opcode reset
// R7 - bit 1 gives shared pin debug function, else output/timer
// R8 - debug pin enable returns to one after every reset
// R9 - bit 0 makes shared pin reset input, else input-only functions
// R10 - pull-up on reset pin follows reset pin enable
// R11 - reset pin enable cleared only by power-on reset; here the first write after a system reset can also clear it
// R12 - second register bit 7 selects watchdog clock, written once
// R13 - second options register takes only first write per reset
// R14 - high identity upper nibble is hard-wired silicon revision
// R15 - 12-bit part number split over high and low identity
// R16 - wakeup register resets to zero with fixed bit layout
// R17 - timeout flag read-only, set on timeout, interrupts when enabled
// R18 - writing one to acknowledge clears flag, reads as zero
// R19 - clock select picks 1 kHz or 32 kHz wakeup base
// R20 - period code zero disables, others select the period
// R21 - each write-once register has its own independent lock
`timescale 1ns/10ps
`default_nettype none
module system_option_id_regs
  import sysopt_pkg::*;
#(
  parameter logic [3:0]  REVISION    = 4'h3,   // arbitrary value
  parameter logic [11:0] PART_NUMBER = 12'h0A5 // arbitrary value
)(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            powerOnReset,
  input  wire sysopt_pkg::wb_req_t wbReq,
  output logic [31:0]          wbDatOut,
  output logic                 wbAck,
  output sysopt_pkg::sysopt_t  options,
  input  wire logic            stopRequest,
  output logic                 stopEnter,
  output logic                 illegalOpReset,
  input  wire logic            slowTickPin,
  input  wire logic            fastTickPin,
  output logic                 wakeupIrq,
  input  wire logic            debugDrive,
  input  wire logic            debugOut,
  input  wire logic            portOutBitFour,
  input  wire logic            timerTwoChanOutput,
  input  wire logic            timerTwoOutEnable,
  input  wire logic            debugModePinIn,
  output logic                 debugModePinOut,
  output logic                 debugModePinOeN,
  output logic                 debugIn,
  input  wire logic            resetSharedPin,
  output logic                 resetPullupEnable,
  output logic                 externalResetReq,
  output logic                 portInBitFive,
  output logic                 timerTwoChanInput,
  output logic                 irqPinLevel
);

  // register state
  logic [7:0]  opt1_r, opt1_nxt;
  logic [7:0]  opt2_r, opt2_nxt;
  logic [7:0]  wake_r, wake_nxt;
  logic        lock1_r, lock1_nxt;
  logic        lock2_r, lock2_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0]  readByte;
  logic        reqLive, wrCommit;
  logic        wrOpt1, wrOpt2, wrWake;
  logic        wakeTimeout;

  // pad synchronisers; stage one feeds stage two only
  logic [3:0] sync1_r, sync2_r;
  logic       slowPrev_r, fastPrev_r;
  logic       slowTick, fastTick;

  // event and pad outputs
  logic stopEnter_r, stopEnter_nxt;
  logic illegal_r, illegal_nxt;
  logic padOut_r, padOut_nxt;
  logic padOeN_r, padOeN_nxt;

  // bus decode; writes commit on the edge that the master sees ack
  always_comb begin
    reqLive  = wbReq.cyc && wbReq.stb;
    wrCommit = reqLive && wbReq.we && ack_r && wbReq.sel[0];
    wrOpt1   = wrCommit && wbReq.adr == OFF_OPT_ONE;
    wrOpt2   = wrCommit && wbReq.adr == OFF_OPT_TWO;
    wrWake   = wrCommit && wbReq.adr == OFF_WAKE_CTRL;
    unique case (wbReq.adr)
      OFF_OPT_ONE:   readByte = opt1_r & OPT1_MASK;
      OFF_OPT_TWO:   readByte = opt2_r & OPT2_MASK;
      OFF_ID_HIGH:   readByte = {REVISION, PART_NUMBER[11:8]}; // R14 R15
      OFF_ID_LOW:    readByte = PART_NUMBER[7:0]; // R15
      OFF_WAKE_CTRL: readByte = wake_r; // R18
      default:       readByte = 8'h00; // unmapped reads zero
    endcase
    ack_nxt = reqLive && !ack_r;
    dat_nxt = (reqLive && !ack_r) ? {24'h000000, readByte} : dat_r;
  end

  // option registers and their independent locks
  always_comb begin
    opt1_nxt  = opt1_r;
    opt2_nxt  = opt2_r;
    lock1_nxt = lock1_r;
    lock2_nxt = lock2_r;
    if (wrOpt1 && !lock1_r) begin
      opt1_nxt  = wbReq.dat[7:0] & OPT1_MASK; // R1 R3 R4 R5 R6 R7 R9
      lock1_nxt = 1'b1; // R21
    end
    if (wrOpt2 && !lock2_r) begin
      opt2_nxt  = wbReq.dat[7:0] & OPT2_MASK; // R12 R13
      lock2_nxt = 1'b1; // R21
    end
  end

  // wakeup flag: a timeout in the ack cycle keeps the flag set
  always_comb begin
    wake_nxt = wake_r;
    if (wrWake) begin
      wake_nxt[5:0] = wbReq.dat[5:0] & WAKE_MASK[5:0]; // R16 R19 R20
      if (wbReq.dat[WAKE_ACK]) begin
        wake_nxt[WAKE_FLAG] = 1'b0; // R18
      end
    end
    if (wakeTimeout) begin
      wake_nxt[WAKE_FLAG] = 1'b1; // R17
    end
  end

  // system reset keeps the reset pin bit unless power-on
  always_ff @(posedge clk) begin
    if (rst) begin
      opt1_r[7:1] <= OPT1_RESET[7:1]; // R8
      if (powerOnReset) begin
        opt1_r[OPT1_RST_PIN] <= 1'b0; // R11
      end
      opt2_r  <= OPT2_RESET;
      wake_r  <= WAKE_RESET; // R16
      lock1_r <= 1'b0; // R21
      lock2_r <= 1'b0; // R21
      ack_r   <= 1'b0;
      dat_r   <= 32'h00000000;
    end else begin
      opt1_r  <= opt1_nxt;
      opt2_r  <= opt2_nxt;
      wake_r  <= wake_nxt;
      lock1_r <= lock1_nxt;
      lock2_r <= lock2_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
    end
  end

  // pads and tick pins cross in through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r    <= 4'h0;
      sync2_r    <= 4'h0;
      slowPrev_r <= 1'b0;
      fastPrev_r <= 1'b0;
    end else begin
      sync1_r    <= {fastTickPin, slowTickPin, resetSharedPin,
                     debugModePinIn};
      sync2_r    <= sync1_r;
      slowPrev_r <= sync2_r[2];
      fastPrev_r <= sync2_r[3];
    end
  end

  assign slowTick = sync2_r[2] && !slowPrev_r;
  assign fastTick = sync2_r[3] && !fastPrev_r;

  wakeup_counter u_wakeup (
    .clk       (clk),
    .rst       (rst),
    .tick      (wake_r[WAKE_CLKSEL] ? fastTick : slowTick), // R19
    .fastBase  (wake_r[WAKE_CLKSEL]),
    .periodSel (wake_r[2:0]), // R20
    .timeout   (wakeTimeout)
  );

  // stop gate and output pad mux; bit 4 is consulted only by the register read-back
  always_comb begin
    stopEnter_nxt = stopRequest && opt1_r[OPT1_STOP_OK]; // R6
    illegal_nxt   = stopRequest && !opt1_r[OPT1_STOP_OK]; // R6
    if (opt1_r[OPT1_DBG_PIN]) begin
      padOut_nxt = debugOut; // R7
      padOeN_nxt = !debugDrive;
    end else begin
      padOut_nxt = timerTwoOutEnable ? timerTwoChanOutput
                                     : portOutBitFour; // R7
      padOeN_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stopEnter_r <= 1'b0;
      illegal_r   <= 1'b0;
      padOut_r    <= 1'b0;
      padOeN_r    <= 1'b1;
    end else begin
      stopEnter_r <= stopEnter_nxt;
      illegal_r   <= illegal_nxt;
      padOut_r    <= padOut_nxt;
      padOeN_r    <= padOeN_nxt;
    end
  end

  // outputs
  assign wbAck                       = ack_r;
  assign wbDatOut                    = dat_r;
  // one driver for the whole carrier; field-wise drivers upset strict tools
  assign options = '{
    watchdogEnable:      opt1_r[OPT1_WDOG_EN], // R4
    watchdogLongTimeout: opt1_r[OPT1_WDOG_LONG], // R5
    watchdogClockSelect: opt2_r[OPT2_WDOG_CLK], // R12
    stopPermit:          opt1_r[OPT1_STOP_OK],
    debugPinEnable:      opt1_r[OPT1_DBG_PIN],
    resetPinEnable:      opt1_r[OPT1_RST_PIN]
  };
  assign stopEnter                   = stopEnter_r;
  assign illegalOpReset              = illegal_r;
  assign wakeupIrq = wake_r[WAKE_FLAG] && wake_r[WAKE_IRQEN]; // R17
  assign debugModePinOut   = padOut_r;
  assign debugModePinOeN   = padOeN_r;
  assign debugIn           = opt1_r[OPT1_DBG_PIN] && sync2_r[0];
  assign resetPullupEnable = opt1_r[OPT1_RST_PIN]; // R10
  assign externalResetReq  = opt1_r[OPT1_RST_PIN] && !sync2_r[1]; // R9
  assign portInBitFive     = !opt1_r[OPT1_RST_PIN] && sync2_r[1]; // R9
  assign timerTwoChanInput = !opt1_r[OPT1_RST_PIN] && sync2_r[1];
  assign irqPinLevel       = !opt1_r[OPT1_RST_PIN] && sync2_r[1];

  // checks
  lock_one_a: assert property (@(posedge clk) disable iff (rst) // R1
    lock1_r && wrOpt1 |=> $stable(opt1_r))
    else $error("first options register changed after lock");
  lock_two_a: assert property (@(posedge clk) disable iff (rst) // R13
    lock2_r && wrOpt2 |=> $stable(opt2_r))
    else $error("second options register changed after lock");
  spare_store_a: assert property (@(posedge clk) disable iff (rst) // R3
    !lock1_r && wrOpt1 |=> opt1_r[OPT1_SPARE] == $past(wbReq.dat[4]))
    else $error("spare bit not stored on first write");
  wdog_take_a: assert property (@(posedge clk) disable iff (rst) // R4
    !lock1_r && wrOpt1 |=> options.watchdogEnable == $past(wbReq.dat[7]))
    else $error("watchdog enable not taken from first write");
  stop_gate_a: assert property (@(posedge clk) disable iff (rst) // R6
    stopRequest && !options.stopPermit |=> illegalOpReset && !stopEnter)
    else $error("stop not refused while stop forbidden");
  dbg_reset_a: assert property (@(posedge clk) // R8
    rst |=> options.debugPinEnable && !lock1_r)
    else $error("debug pin enable not restored by reset");
  rstpin_keep_a: assert property (@(posedge clk) // R11
    rst && !powerOnReset |=> options.resetPinEnable == $past(opt1_r[0]))
    else $error("reset pin enable lost on system reset");
  rstpin_por_a: assert property (@(posedge clk) // R11
    rst && powerOnReset |=> !options.resetPinEnable && !resetPullupEnable)
    else $error("power-on reset left reset pin enabled");
  flag_set_a: assert property (@(posedge clk) disable iff (rst) // R17
    wakeTimeout |=> wake_r[WAKE_FLAG])
    else $error("timeout did not set wakeup flag");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst) // R18
    wrWake && wbReq.dat[6] && !wakeTimeout |=> !wake_r[WAKE_FLAG])
    else $error("acknowledge did not clear wakeup flag");
  bus_ack_a: assert property (@(posedge clk) disable iff (rst)
    reqLive && !ack_r |=> ack_r ##1 !ack_r)
    else $error("ack not a single cycle one edge after request");
  port_drive_a: assert property (@(posedge clk) disable iff (rst) // R7
    !options.debugPinEnable |=> !debugModePinOeN)
    else $error("output pad not driven in port function");
  wake_off_a: assert property (@(posedge clk) disable iff (rst) // R20
    wake_r[2:0] == 3'h0 |=> !wakeTimeout)
    else $error("wakeup timeout with period code zero");
  lock_apart_a: assert property (@(posedge clk) disable iff (rst) // R21
    !lock2_r && wrOpt2 |=> lock2_r && $stable(lock1_r))
    else $error("second lock not independent of first");

  first_write_c: cover property (@(posedge clk) disable iff (rst)
    wrOpt1 && !lock1_r ##[1:40] wrOpt1);
  wake_irq_c: cover property (@(posedge clk) disable iff (rst)
    wakeupIrq ##[1:40] !wake_r[WAKE_FLAG]);
  illegal_stop_c: cover property (@(posedge clk) disable iff (rst)
    illegalOpReset);
  fast_wake_c: cover property (@(posedge clk) disable iff (rst)
    wakeTimeout && wake_r[WAKE_CLKSEL]);
  soft_keep_c: cover property (@(posedge clk)
    rst && !powerOnReset && opt1_r[OPT1_RST_PIN]);

endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the system option block
// Assumes: classic wishbone master, one access at a time
// Notes:   tick pads come from a free divider of the bus clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sysopt_pkg::*;
  localparam logic [3:0]  REV = 4'h3;    // arbitrary value
  localparam logic [11:0] PN  = 12'h0A5; // arbitrary value

  logic        clk;
  logic        rst;
  logic        powerOnReset;
  wb_req_t     wbReq;
  logic [31:0] wbDatOut;
  logic        wbAck;
  sysopt_t     options;
  logic        stopRequest;
  logic        stopEnter;
  logic        illegalOpReset;
  logic [3:0]  tickCnt = 4'h0;
  wire logic   slowTickPin;
  wire logic   fastTickPin;
  logic        wakeupIrq;
  logic        debugDrive;
  logic        debugOut;
  logic        portOutBitFour;
  logic        timerTwoChanOutput;
  logic        timerTwoOutEnable;
  logic        debugModePinIn;
  logic        debugModePinOut;
  logic        debugModePinOeN;
  logic        debugIn;
  logic        resetSharedPin;
  logic        resetPullupEnable;
  logic        externalResetReq;
  logic        portInBitFive;
  logic        timerTwoChanInput;
  logic        irqPinLevel;
  int          miscompares = 0;
  int          totalChecks = 0;

  system_option_id_regs #(.REVISION(REV), .PART_NUMBER(PN))
    i_system_option_id_regs (.clk(clk), .rst(rst),
    .powerOnReset(powerOnReset), .wbReq(wbReq), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .options(options), .stopRequest(stopRequest),
    .stopEnter(stopEnter), .illegalOpReset(illegalOpReset),
    .slowTickPin(slowTickPin), .fastTickPin(fastTickPin),
    .wakeupIrq(wakeupIrq), .debugDrive(debugDrive), .debugOut(debugOut),
    .portOutBitFour(portOutBitFour),
    .timerTwoChanOutput(timerTwoChanOutput),
    .timerTwoOutEnable(timerTwoOutEnable),
    .debugModePinIn(debugModePinIn), .debugModePinOut(debugModePinOut),
    .debugModePinOeN(debugModePinOeN), .debugIn(debugIn),
    .resetSharedPin(resetSharedPin),
    .resetPullupEnable(resetPullupEnable),
    .externalResetReq(externalResetReq), .portInBitFive(portInBitFive),
    .timerTwoChanInput(timerTwoChanInput), .irqPinLevel(irqPinLevel));

  // slow base ticks every 16 cycles, fast every 4, so bases differ
  always @(posedge clk) begin
    tickCnt <= tickCnt + 4'h1;
  end
  assign slowTickPin = tickCnt[3];
  assign fastTickPin = tickCnt[1];

  task automatic stop_test();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wbCycle(input logic we, input logic [7:0] adr,
      input logic [7:0] wdat, input logic [3:0] sel,
      output logic [7:0] rdat);
    int n;
    n = 0;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
               dat: {24'h000000, wdat}};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    rdat = wbDatOut[7:0];
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] r;
    wbCycle(1'b1, adr, d, 4'h1, r);
  endtask

  task automatic rd(input string nm, input logic [7:0] adr, exp);
    logic [7:0] r;
    wbCycle(1'b0, adr, 8'h00, 4'h1, r);
    chk(nm, 32'(r), 32'(exp));
  endtask

  task automatic bit1(input string nm, input logic seen, exp);
    chk(nm, 32'(seen), 32'(exp));
  endtask

  task automatic doReset(input logic por);
    @(posedge clk);
    rst <= 1'b1;
    powerOnReset <= por;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    powerOnReset <= 1'b0;
  endtask

  // bounded wait for the wakeup request
  task automatic waitIrq(input int bound);
    int n;
    n = 0;
    while (wakeupIrq !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    bit1("wakeupIrq", wakeupIrq, 1'b1);
    if (wakeupIrq !== 1'b1) stop_test();
  endtask

  task automatic t_reset_values();
    rd("optOne", OFF_OPT_ONE, 8'hD2);
    rd("optTwo", OFF_OPT_TWO, 8'h00);
    rd("idHigh", OFF_ID_HIGH, {REV, PN[11:8]});
    rd("idLow", OFF_ID_LOW, PN[7:0]);
    rd("wake", OFF_WAKE_CTRL, 8'h00);
    rd("unmapped", 8'h14, 8'h00);
    bit1("wdogEn", options.watchdogEnable, 1'b1);
    bit1("wdogLong", options.watchdogLongTimeout, 1'b1);
    bit1("stopOk", options.stopPermit, 1'b0);
    bit1("dbgPin", options.debugPinEnable, 1'b1);
    bit1("rstPin", options.resetPinEnable, 1'b0);
    bit1("pullup", resetPullupEnable, 1'b0);
  endtask

  task automatic t_pins_default();
    @(posedge clk);
    debugModePinIn <= 1'b1;
    debugDrive <= 1'b1;
    debugOut <= 1'b0;
    repeat (6) @(posedge clk);
    bit1("portIn", portInBitFive, 1'b1);
    bit1("irqPin", irqPinLevel, 1'b1);
    bit1("tmrIn", timerTwoChanInput, 1'b1);
    bit1("extRst", externalResetReq, 1'b0);
    bit1("debugIn", debugIn, 1'b1);
    bit1("padOut", debugModePinOut, 1'b0);
    bit1("padOeN", debugModePinOeN, 1'b0);
    // debug engine lets go of the pad: active-low enable must go high
    debugDrive <= 1'b0;
    repeat (2) @(posedge clk);
    bit1("padOeN", debugModePinOeN, 1'b1);
  endtask

  task automatic t_write_once();
    wr(OFF_OPT_ONE, 8'h31);
    rd("optOne", OFF_OPT_ONE, 8'h31);
    wr(OFF_OPT_ONE, 8'hCE);
    rd("optOne", OFF_OPT_ONE, 8'h31);
    wr(OFF_OPT_TWO, 8'h80);
    rd("optTwo", OFF_OPT_TWO, 8'h80);
    wr(OFF_OPT_TWO, 8'h00);
    rd("optTwo", OFF_OPT_TWO, 8'h80);
    wr(OFF_ID_LOW, 8'hFF);
    rd("idLow", OFF_ID_LOW, PN[7:0]);
    bit1("wdogEn", options.watchdogEnable, 1'b0);
    bit1("wdogLong", options.watchdogLongTimeout, 1'b0);
    bit1("stopOk", options.stopPermit, 1'b1);
    bit1("dbgPin", options.debugPinEnable, 1'b0);
    bit1("rstPin", options.resetPinEnable, 1'b1);
    bit1("wdogClk", options.watchdogClockSelect, 1'b1);
  endtask

  task automatic t_pins_alternate();
    @(posedge clk);
    resetSharedPin <= 1'b0;
    repeat (6) @(posedge clk);
    bit1("extRst", externalResetReq, 1'b1);
    bit1("portIn", portInBitFive, 1'b0);
    bit1("pullup", resetPullupEnable, 1'b1);
    bit1("debugIn", debugIn, 1'b0);
    bit1("padOut", debugModePinOut, 1'b1);
    bit1("padOeN", debugModePinOeN, 1'b0);
    timerTwoOutEnable <= 1'b1;
    resetSharedPin <= 1'b1;
    repeat (6) @(posedge clk);
    bit1("padOut", debugModePinOut, 1'b0);
  endtask

  task automatic t_stop(input logic permit);
    @(posedge clk);
    stopRequest <= 1'b1;
    @(posedge clk);
    stopRequest <= 1'b0;
    @(posedge clk);
    bit1("stopEnter", stopEnter, permit);
    bit1("illegalOp", illegalOpReset, !permit);
    @(posedge clk);
    bit1("stopEnter", stopEnter, 1'b0);
  endtask

  task automatic t_soft_reset();
    doReset(1'b0);
    rd("optOne", OFF_OPT_ONE, 8'hD3);
    rd("optTwo", OFF_OPT_TWO, 8'h00);
    bit1("dbgPin", options.debugPinEnable, 1'b1);
    t_stop(1'b0);
    wr(OFF_OPT_TWO, 8'h80);
    wr(OFF_OPT_ONE, 8'h12);
    rd("optOne", OFF_OPT_ONE, 8'h12);
    rd("optTwo", OFF_OPT_TWO, 8'h80);
    doReset(1'b1);
    rd("optOne", OFF_OPT_ONE, 8'hD2);
  endtask

  task automatic t_wakeup();
    logic [7:0] r;
    wr(OFF_WAKE_CTRL, 8'h11);
    waitIrq(400);
    rd("wake", OFF_WAKE_CTRL, 8'h91);
    wr(OFF_WAKE_CTRL, 8'h51);
    rd("wake", OFF_WAKE_CTRL, 8'h11);
    bit1("wakeupIrq", wakeupIrq, 1'b0);
    wr(OFF_WAKE_CTRL, 8'h01);
    repeat (300) @(posedge clk);
    bit1("wakeupIrq", wakeupIrq, 1'b0);
    rd("wake", OFF_WAKE_CTRL, 8'h81);
    wr(OFF_WAKE_CTRL, 8'h4F);
    rd("wake", OFF_WAKE_CTRL, 8'h07);
    // fast base must not fire in the time the slow base would
    wr(OFF_WAKE_CTRL, 8'h71);
    repeat (300) @(posedge clk);
    bit1("wakeupIrq", wakeupIrq, 1'b0);
    waitIrq(2000);
    rd("wake", OFF_WAKE_CTRL, 8'hB1);
    wr(OFF_WAKE_CTRL, 8'h50);
    repeat (300) @(posedge clk);
    rd("wake", OFF_WAKE_CTRL, 8'h10);
    wbCycle(1'b1, OFF_WAKE_CTRL, 8'h37, 4'h0, r);
    rd("wake", OFF_WAKE_CTRL, 8'h10);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    powerOnReset = 1'b1;
    wbReq = '0;
    stopRequest = 1'b0;
    debugDrive = 1'b0;
    debugOut = 1'b0;
    portOutBitFour = 1'b1;
    timerTwoChanOutput = 1'b0;
    timerTwoOutEnable = 1'b0;
    debugModePinIn = 1'b0;
    resetSharedPin = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    powerOnReset <= 1'b0;
    t_reset_values();
    t_pins_default();
    t_write_once();
    t_pins_alternate();
    t_stop(1'b1);
    t_soft_reset();
    t_wakeup();
    stop_test();
  end
endmodule
`default_nettype wire
